// File: rtl/acq_trigger_arm_control.sv
// Trigger selection and arming of the multi-bunch and single-bunch acquisition engines.
`timescale 1ns/10ps
module acq_trigger_arm_control
   import acq_trig_pkg::*;
#(
   parameter logic [LEN_W-1:0] MAX_TURNS = 24'h01_8000
)
(
   input wire logic clk, // System clock, 100 MHz.
   input wire logic reset, // Asynchronous reset, active high.
   input wire logic hsel, // AHB slave select.
   input wire logic [31:0] haddr, // AHB address.
   input wire logic [1:0] htrans, // AHB transfer type.
   input wire logic hwrite, // AHB write.
   input wire logic [2:0] hsize, // AHB size, word only.
   input wire logic [31:0] hwdata, // AHB write data.
   input wire logic hready, // AHB bus ready.
   output logic hreadyout, // AHB slave ready.
   output logic hresp, // AHB response, always OKAY.
   output logic [31:0] hrdata, // AHB read data.
   output logic irq, // Level interrupt.
   input wire logic ext_trigger_input_a, // External trigger pin a.
   input wire logic ext_trigger_input_b, // External trigger pin b.
   input wire logic [NUM_ENG-1:0] int_trigger, // Internal trigger pulses per engine.
   input wire logic bunch_strobe, // One pulse per bunch.
   input wire logic turn_strobe, // One pulse per turn, at bunch one.
   input wire logic [DATA_W-1:0] sample_in, // Bunch sample stream.
   output logic [NUM_ENG-1:0] acq_active, // Capture in progress per engine.
   output logic sb_sample_valid, // Single-bunch sample pulse.
   output logic [DATA_W-1:0] sb_sample_data // Single-bunch sample.
);
   typedef struct packed {
      logic [31:0] ctrl;
      logic [LEN_W-1:0] len_mb;
      logic [LEN_W-1:0] len_sb;
      logic [BUNCH_W-1:0] bunch_sel;
      logic [BUNCH_W-1:0] cur_bunch;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      eng_state_e [NUM_ENG-1:0] st;
      logic [NUM_ENG-1:0][LEN_W-1:0] turns;
      logic [NUM_ENG-1:0][1:0] lvl;
      logic [NUM_ENG-1:0] was_ext;
      logic dph_wr;
      logic [7:0] dph_addr;
      logic [31:0] rdata;
   } ctl_s;
   ctl_s s_r;
   ctl_s s_nxt;

   logic lvl_a;
   logic lvl_b;
   logic rise_a;
   logic rise_b;
   logic [BUNCH_W-1:0] recorded_idx;
   logic addr_ok;
   logic [7:0] word_addr;
   logic [NUM_ENG-1:0] arm_cmd;
   logic [NUM_ENG-1:0] read_cmd;
   logic [IRQ_W-1:0] irq_set;
   logic [LEN_W-1:0] sb_samples;

   trig_cond u_trig_a (
      .clk(clk),
      .reset(reset),
      .pin(ext_trigger_input_a),
      .falling(s_r.ctrl[CTRL_FALL_A_POS]),
      .level(lvl_a),
      .rise(rise_a)
   );

   trig_cond u_trig_b (
      .clk(clk),
      .reset(reset),
      .pin(ext_trigger_input_b),
      .falling(s_r.ctrl[CTRL_FALL_B_POS]),
      .level(lvl_b),
      .rise(rise_b)
   );

   bunch_select u_bunch (
      .clk(clk),
      .reset(reset),
      .bunch_strobe(bunch_strobe),
      .turn_strobe(turn_strobe),
      .capture(s_r.st[ENG_SB] == ENG_CAPTURE),
      .bunch_sel(s_r.bunch_sel),
      .sample_in(sample_in),
      .sample_valid(sb_sample_valid),
      .sample_data(sb_sample_data),
      .recorded_idx(recorded_idx)
   );

   // Capture length in turns, limited to what one sample per turn allows.
   function automatic logic [LEN_W-1:0] clamp_len(input logic [LEN_W-1:0] len);
      logic [LEN_W-1:0] l;
      l = (len == '0) ? LEN_W'(1) : len;
      if (l > MAX_TURNS) begin
         l = MAX_TURNS;
      end
      return l;
   endfunction

   // Control bit of engine e at base position pos.
   function automatic logic eng_bit(input logic [31:0] ctrl, input int e, input int pos);
      return ctrl[e * ENG_STRIDE + pos];
   endfunction

   assign sb_samples = clamp_len(s_r.len_sb);
   assign word_addr = {haddr[7:2], 2'b00};
   assign addr_ok = hsel & hready & htrans[1];

   // Read data for the address phase; the value goes out in the data phase.
   function automatic logic [31:0] read_mux(input ctl_s s, input logic [7:0] a,
                                            input logic [LEN_W-1:0] smp);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         OFF_CTRL: d = s.ctrl;
         OFF_STATUS: begin
            for (int e = 0; e < NUM_ENG; e++) begin
               d[e * ENG_STRIDE + ST_ARMED_POS] = (s.st[e] == ENG_ARMED);
               d[e * ENG_STRIDE + ST_ACTIVE_POS] = (s.st[e] == ENG_CAPTURE);
               d[e * ENG_STRIDE + ST_DONE_POS] = (s.st[e] == ENG_DONE);
               d[e * ENG_STRIDE + ST_LVL_A_POS] = s.lvl[e][0];
               d[e * ENG_STRIDE + ST_LVL_B_POS] = s.lvl[e][1];
            end
         end
         OFF_LEN_MB: d = {{(32 - LEN_W){1'b0}}, s.len_mb};
         OFF_LEN_SB: d = {{(32 - LEN_W){1'b0}}, s.len_sb};
         OFF_BUNCH_SEL: d = {{(32 - BUNCH_W){1'b0}}, s.bunch_sel};
         OFF_CUR_BUNCH: d = {{(32 - BUNCH_W){1'b0}}, s.cur_bunch};
         OFF_SAMPLE_CNT: d = {{(32 - LEN_W){1'b0}}, smp};
         OFF_IRQ_STATUS: d = {{(32 - IRQ_W){1'b0}}, s.irq_stat};
         OFF_IRQ_MASK: d = {{(32 - IRQ_W){1'b0}}, s.irq_mask};
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   always_comb begin
      logic ext_trig;
      logic go;
      logic [LEN_W-1:0] len;
      ext_trig = 1'b0;
      go = 1'b0;
      len = '0;
      s_nxt = s_r;
      irq_set = '0;
      arm_cmd = '0;
      read_cmd = '0;

      // Address phase: latch the write target, or fetch the read word.
      s_nxt.dph_wr = addr_ok & hwrite;
      s_nxt.dph_addr = word_addr;
      if (addr_ok && !hwrite) begin
         s_nxt.rdata = read_mux(s_r, word_addr, sb_samples);
      end

      // Data phase of a write.
      if (s_r.dph_wr) begin
         case (s_r.dph_addr)
            OFF_CTRL: s_nxt.ctrl = hwdata;
            OFF_CMD: begin
               for (int e = 0; e < NUM_ENG; e++) begin
                  arm_cmd[e] = hwdata[CMD_ARM_POS + e];
                  read_cmd[e] = hwdata[CMD_READ_POS + e];
               end
            end
            OFF_LEN_MB: s_nxt.len_mb = hwdata[LEN_W-1:0];
            OFF_LEN_SB: s_nxt.len_sb = hwdata[LEN_W-1:0];
            OFF_BUNCH_SEL: s_nxt.bunch_sel = hwdata[BUNCH_W-1:0];
            OFF_IRQ_MASK: s_nxt.irq_mask = hwdata[IRQ_W-1:0];
            default: s_nxt.ctrl = s_r.ctrl;
         endcase
      end

      for (int e = 0; e < NUM_ENG; e++) begin
         // Input b or input a, after polarity, feeds the external path.
         ext_trig = eng_bit(s_r.ctrl, e, CTRL_INB_POS) ? rise_b : rise_a;
         if (eng_bit(s_r.ctrl, e, CTRL_EXT_POS)) begin
            go = (s_r.st[e] == ENG_ARMED) && ext_trig;
         end else begin
            go = (s_r.st[e] == ENG_IDLE || s_r.st[e] == ENG_DONE) && int_trigger[e];
         end
         len = (e == ENG_SB) ? sb_samples : clamp_len(s_r.len_mb);
         case (s_r.st[e])
            ENG_IDLE, ENG_DONE: begin
               if (go) begin
                  s_nxt.st[e] = ENG_CAPTURE;
               end else if (arm_cmd[e]) begin
                  s_nxt.st[e] = ENG_ARMED;
               end else if (read_cmd[e] && s_r.st[e] == ENG_DONE) begin
                  // With auto re-arm on, only a capture that came from an external trigger re-arms itself.
                  if (eng_bit(s_r.ctrl, e, CTRL_AUTO_POS) && s_r.was_ext[e]) begin
                     s_nxt.st[e] = ENG_ARMED;
                  end else begin
                     s_nxt.st[e] = ENG_IDLE;
                  end
               end
            end
            ENG_ARMED: begin
               if (go) begin
                  s_nxt.st[e] = ENG_CAPTURE;
               end
            end
            ENG_CAPTURE: begin
               // Triggers and arm commands are ignored until the capture ends.
               if (turn_strobe) begin
                  s_nxt.turns[e] = s_r.turns[e] + LEN_W'(1);
                  if (s_r.turns[e] + LEN_W'(1) >= len) begin
                     s_nxt.st[e] = ENG_DONE;
                     irq_set[IRQ_DONE_POS + e] = 1'b1;
                     if (e == ENG_SB) begin
                        s_nxt.cur_bunch = recorded_idx;
                     end
                  end
               end
            end
            default: s_nxt.st[e] = ENG_IDLE;
         endcase
         if (go) begin
            s_nxt.turns[e] = '0;
            s_nxt.lvl[e] = {lvl_b, lvl_a};
            s_nxt.was_ext[e] = eng_bit(s_r.ctrl, e, CTRL_EXT_POS);
            irq_set[e] = 1'b1;
         end
      end

      // A read of the status clears it, but an event in the same cycle is kept.
      if (addr_ok && !hwrite && word_addr == OFF_IRQ_STATUS) begin
         s_nxt.irq_stat = irq_set;
      end else begin
         s_nxt.irq_stat = s_r.irq_stat | irq_set;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_r <= '0;
         s_r.ctrl <= CTRL_RESET;
         s_r.len_mb <= LEN_RESET;
         s_r.len_sb <= LEN_RESET;
         s_r.bunch_sel <= BUNCH_SEL_RESET;
         s_r.irq_mask <= IRQ_MASK_RESET;
         s_r.st <= {NUM_ENG{ENG_IDLE}};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_r.rdata;
   assign irq = |(s_r.irq_stat & s_r.irq_mask);

   always_comb begin
      for (int e = 0; e < NUM_ENG; e++) begin
         acq_active[e] = (s_r.st[e] == ENG_CAPTURE);
      end
   end
endmodule

// File: rtl/acq_trig_pkg.sv
// Package with the register map, field positions and types of the trigger and arm control.
// Operation
// - Each engine has a control bit that picks an internal or an external start trigger.
// - With external triggering, a second per-engine bit picks input a or input b.
// - An external trigger is taken only while the engine is armed.
// - One arm command allows exactly one externally triggered capture.
// - With auto re-arm on, a readout of data from an externally triggered capture arms the engine again.
// - Both internal trigger levels are latched when a capture starts and read back as two bits.
// - The latched levels are those after polarity selection, not the raw pin levels.
// - The single-bunch engine records only the bunch whose one-based index is programmed.
// - The index of the bunch recorded by the last completed capture is readable.
// - A single-bunch capture takes one sample per turn over a programmed number of turns.
// - A falling-edge selection inverts the trigger before the engines see it.
package acq_trig_pkg;
   localparam int NUM_ENG = 2;
   localparam int LEN_W = 24;
   localparam int BUNCH_W = 12;
   localparam int DATA_W = 16;
   localparam int ENG_MB = 0;
   localparam int ENG_SB = 1;
   // Byte offsets of the registers.
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_LEN_MB = 8'h0C;
   localparam logic [7:0] OFF_LEN_SB = 8'h10;
   localparam logic [7:0] OFF_BUNCH_SEL = 8'h14;
   localparam logic [7:0] OFF_CUR_BUNCH = 8'h18;
   localparam logic [7:0] OFF_SAMPLE_CNT = 8'h1C;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
   // Control fields: engine e uses bits at e*ENG_STRIDE plus the base position; the two polarity bits are shared by both engines.
   localparam int ENG_STRIDE = 8;
   localparam int CTRL_EXT_POS = 0;
   localparam int CTRL_INB_POS = 1;
   localparam int CTRL_AUTO_POS = 2;
   localparam int CTRL_FALL_A_POS = 16;
   localparam int CTRL_FALL_B_POS = 17;
   // Command fields: arm at bit e, readout done at bit e + CMD_READ_POS.
   localparam int CMD_ARM_POS = 0;
   localparam int CMD_READ_POS = 4;
   // Status fields per engine at e*ENG_STRIDE.
   localparam int ST_ARMED_POS = 0;
   localparam int ST_ACTIVE_POS = 1;
   localparam int ST_DONE_POS = 2;
   localparam int ST_LVL_A_POS = 4;
   localparam int ST_LVL_B_POS = 5;
   // Interrupt events: trigger taken at bit e, capture done at bit e + IRQ_DONE_POS.
   localparam int IRQ_W = 4;
   localparam int IRQ_DONE_POS = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [LEN_W-1:0] LEN_RESET = 24'h00_0001;
   localparam logic [BUNCH_W-1:0] BUNCH_SEL_RESET = 12'h001;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
   typedef enum logic [1:0] {
      ENG_IDLE,
      ENG_ARMED,
      ENG_CAPTURE,
      ENG_DONE
   } eng_state_e;
endpackage

// File: rtl/trig_cond.sv
// One external trigger input: synchroniser, polarity inversion and edge detector.
`timescale 1ns/10ps
module trig_cond
   import acq_trig_pkg::*;
(
   input wire logic clk, // System clock.
   input wire logic reset, // Asynchronous reset, active high.
   input wire logic pin, // Raw trigger pin, asynchronous.
   input wire logic falling, // High selects the falling edge.
   output logic level, // Internal trigger level after polarity.
   output logic rise // One-cycle pulse on an internal rising edge.
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic lvl;
      logic prev;
   } cond_s;
   cond_s s_r;
   cond_s s_nxt;

   // The first stage feeds only the second; polarity acts after the synchroniser.
   always_comb begin
      s_nxt = s_r;
      s_nxt.meta = pin;
      s_nxt.sync = s_r.meta;
      s_nxt.lvl = s_r.sync ^ falling;
      s_nxt.prev = s_r.lvl;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Changing the polarity while the pin is steady reads as an edge; arm after setting it.
   assign level = s_r.lvl;
   // The pulse comes from registers so that level already shows the new state with it.
   assign rise = s_r.lvl & ~s_r.prev;
endmodule

// File: rtl/bunch_select.sv
// Single-bunch sampler: tracks the bunch index around the turn and picks one bunch.
`timescale 1ns/10ps
module bunch_select
   import acq_trig_pkg::*;
(
   input wire logic clk, // System clock.
   input wire logic reset, // Asynchronous reset, active high.
   input wire logic bunch_strobe, // One pulse per bunch.
   input wire logic turn_strobe, // Marks bunch one, with its bunch strobe.
   input wire logic capture, // Single-bunch capture in progress.
   input wire logic [BUNCH_W-1:0] bunch_sel, // Bunch to record, counted from one.
   input wire logic [DATA_W-1:0] sample_in, // Bunch sample stream.
   output logic sample_valid, // One-cycle pulse with a recorded sample.
   output logic [DATA_W-1:0] sample_data, // Recorded sample.
   output logic [BUNCH_W-1:0] recorded_idx // Index of the last recorded bunch.
);
   typedef struct packed {
      logic [BUNCH_W-1:0] idx;
      logic valid;
      logic [DATA_W-1:0] data;
      logic [BUNCH_W-1:0] rec;
   } sel_s;
   sel_s s_r;
   sel_s s_nxt;
   logic [BUNCH_W-1:0] cur_idx;

   always_comb begin
      s_nxt = s_r;
      s_nxt.valid = 1'b0;
      cur_idx = turn_strobe ? BUNCH_W'(1) : s_r.idx + BUNCH_W'(1);
      if (bunch_strobe) begin
         s_nxt.idx = cur_idx;
         if (capture && cur_idx == bunch_sel) begin
            s_nxt.valid = 1'b1;
            s_nxt.data = sample_in;
            s_nxt.rec = cur_idx;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sample_valid = s_r.valid;
   assign sample_data = s_r.data;
   assign recorded_idx = s_r.rec;
endmodule

// File: testbench/acq_trig_chk_sva.sv
// Port checker for the trigger and arm control.
`timescale 1ns/10ps
module acq_trig_chk
   import acq_trig_pkg::*;
(
   input wire logic clk, // Clock.
   input wire logic reset, // Reset, active high.
   input wire logic hsel, // Bus select.
   input wire logic [1:0] htrans, // Transfer type.
   input wire logic hwrite, // Write.
   input wire logic hready, // Bus ready.
   input wire logic hreadyout, // Slave ready.
   input wire logic hresp, // Response.
   input wire logic [31:0] hrdata, // Read data.
   input wire logic ext_trigger_input_a, // Pin a.
   input wire logic ext_trigger_input_b, // Pin b.
   input wire logic [NUM_ENG-1:0] int_trigger, // Internal triggers.
   input wire logic bunch_strobe, // Bunch strobe.
   input wire logic turn_strobe, // Turn strobe.
   input wire logic [NUM_ENG-1:0] acq_active, // Capture flags.
   input wire logic sb_sample_valid // Sample pulse.
);
   logic rd_q;
   logic pa_q;
   logic pb_q;
   logic [3:0] quiet_cnt;
   // Counts cycles since any trigger cause, so a capture start can be tied to one.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_q <= 1'b0;
         pa_q <= 1'b0;
         pb_q <= 1'b0;
         quiet_cnt <= 4'hF;
      end else begin
         rd_q <= hsel && hready && htrans[1] && !hwrite;
         pa_q <= ext_trigger_input_a;
         pb_q <= ext_trigger_input_b;
         if (ext_trigger_input_a != pa_q || ext_trigger_input_b != pb_q || |int_trigger) begin
            quiet_cnt <= 4'h0;
         end else if (quiet_cnt != 4'hF) begin
            quiet_cnt <= quiet_cnt + 4'h1;
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_sb_pulse;
      sb_sample_valid ##1 !sb_sample_valid;
   endsequence
   property p_ready; hreadyout; endproperty
   property p_okay; !hresp; endproperty
   property p_rd_hold; !rd_q |-> $stable(hrdata); endproperty
   property p_sb_pulse; sb_sample_valid |-> s_sb_pulse; endproperty
   property p_sb_strobe;
      sb_sample_valid |-> ($past(bunch_strobe) || $past(bunch_strobe, 2) || $past(bunch_strobe, 3));
   endproperty
   property p_sb_active;
      sb_sample_valid |-> (acq_active[1] || $past(acq_active[1]) || $past(acq_active[1], 2));
   endproperty
   property p_end_turn;
      ($fell(acq_active[0]) || $fell(acq_active[1]))
         |-> ($past(turn_strobe) || $past(turn_strobe, 2) || $past(turn_strobe, 3));
   endproperty
   property p_start_cause;
      ($rose(acq_active[0]) || $rose(acq_active[1])) |-> quiet_cnt < 4'h8;
   endproperty
   a_ready: assert property (p_ready) else $error("hreadyout low");
   a_okay: assert property (p_okay) else $error("hresp not okay");
   a_rd_hold: assert property (p_rd_hold) else $error("hrdata changed without a read");
   a_sb_pulse: assert property (p_sb_pulse) else $error("sample pulse too long");
   a_sb_strobe: assert property (p_sb_strobe) else $error("sample without bunch");
   a_sb_active: assert property (p_sb_active) else $error("sample outside capture");
   a_end_turn: assert property (p_end_turn) else $error("capture ended off turn");
   a_start_cause: assert property (p_start_cause) else $error("capture without trigger");
endmodule
bind acq_trigger_arm_control acq_trig_chk u_chk (.clk, .reset, .hsel, .htrans, .hwrite, .hready,
   .hreadyout, .hresp, .hrdata, .ext_trigger_input_a, .ext_trigger_input_b, .int_trigger,
   .bunch_strobe, .turn_strobe, .acq_active, .sb_sample_valid);

// File: testbench/beam_src.sv
// Beam timing model: bunch and turn strobes with a sample stream tagged by bunch index.
`timescale 1ns/10ps
module beam_src #(
   parameter int NB = 4
)
(
   input wire logic clk, // Clock.
   input wire logic reset, // Reset, active high.
   output logic bunch_strobe, // One pulse per bunch.
   output logic turn_strobe, // With the strobe of bunch one.
   output logic [15:0] sample_in // Bunch sample.
);
   logic [1:0] ph_r;
   logic [7:0] idx_r;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ph_r <= 2'h0;
         idx_r <= 8'h01;
         bunch_strobe <= 1'b0;
         turn_strobe <= 1'b0;
         sample_in <= 16'h0000;
      end else begin
         ph_r <= ph_r + 2'h1;
         bunch_strobe <= (ph_r == 2'h3);
         turn_strobe <= (ph_r == 2'h3) && (idx_r == 8'h01);
         // Between strobes the stream toggles so a late sample cannot match.
         sample_in <= (ph_r == 2'h3) ? (16'hA000 | {8'h00, idx_r}) : ~sample_in;
         if (ph_r == 2'h3) begin
            idx_r <= (idx_r == 8'(NB)) ? 8'h01 : idx_r + 8'h01;
         end
      end
   end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench of the trigger and arm control.
`timescale 1ns/10ps
module tb_top
   import acq_trig_pkg::*;
;
   typedef struct {logic [7:0] a; logic [31:0] v;} row_s;
   logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, irq, hreadyout, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0, int_trigger = 2'h0, acq_active;
   logic [2:0] hsize = 3'h2;
   logic ext_trigger_input_a = 1'b0, ext_trigger_input_b = 1'b0;
   logic bunch_strobe, turn_strobe, sb_sample_valid;
   logic [15:0] sample_in, sb_sample_data, sb_last;
   wire logic hready = hreadyout;
   int err_total = 0, checked = 0, cyc = 0, sb_cnt = 0;
   row_s rows[7] = '{'{OFF_CTRL, 32'h0}, '{OFF_STATUS, 32'h0}, '{OFF_LEN_MB, 32'h1},
      '{OFF_LEN_SB, 32'h1}, '{OFF_BUNCH_SEL, 32'h1}, '{OFF_IRQ_MASK, 32'h0}, '{8'h3C, 32'h0}};
   acq_trigger_arm_control #(.MAX_TURNS(24'h00_0008)) dut (.clk, .reset, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq,
      .ext_trigger_input_a, .ext_trigger_input_b, .int_trigger, .bunch_strobe, .turn_strobe,
      .sample_in, .acq_active, .sb_sample_valid, .sb_sample_data);
   beam_src src (.clk, .reset, .bunch_strobe, .turn_strobe, .sample_in);
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (sb_sample_valid === 1'b1) begin
         sb_cnt++;
         sb_last = sb_sample_data;
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   task stop_test();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task chkb(input string n, input logic e, input logic g);
      chk(n, {31'h0, e}, {31'h0, g});
   endtask
   // The master waits for ready with no assumed latency; the cycle limit ends a hang.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task rd(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(n, e, q);
   endtask
   task wait_act(input int e, input logic v);
      for (int i = 0; i < 200 && acq_active[e] !== v; i++) @(posedge clk);
      chkb("acq_active", v, acq_active[e]);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chkb("irq", 1'b0, irq);
      foreach (rows[i]) rd("reset value", rows[i].a, rows[i].v);
      wr(OFF_IRQ_MASK, 32'h8);
      wr(OFF_LEN_MB, 32'h2);
      wr(OFF_LEN_SB, 32'h2);
      wr(OFF_BUNCH_SEL, 32'h3);
      wr(OFF_CTRL, 32'h1);
      ext_trigger_input_a <= 1'b1;
      repeat (10) @(posedge clk);
      rd("status", OFF_STATUS, 32'h0);
      ext_trigger_input_a <= 1'b0;
      repeat (6) @(posedge clk);
      wr(OFF_CMD, 32'h1);
      rd("status", OFF_STATUS, 32'h1);
      ext_trigger_input_a <= 1'b1;
      wait_act(0, 1'b1);
      rd("status", OFF_STATUS, 32'h12);
      ext_trigger_input_a <= 1'b0;
      repeat (6) @(posedge clk);
      ext_trigger_input_a <= 1'b1;
      wait_act(0, 1'b0);
      repeat (10) @(posedge clk);
      chkb("acq_active", 1'b0, acq_active[0]);
      rd("status", OFF_STATUS, 32'h14);
      chkb("irq", 1'b0, irq);
      rd("irq status", OFF_IRQ_STATUS, 32'h5);
      rd("irq status", OFF_IRQ_STATUS, 32'h0);
      ext_trigger_input_a <= 1'b0;
      wr(OFF_CMD, 32'h10);
      wr(OFF_CTRL, 32'h0002_0007);
      repeat (8) @(posedge clk);
      wr(OFF_CMD, 32'h1);
      ext_trigger_input_a <= 1'b1;
      repeat (8) @(posedge clk);
      chkb("acq_active", 1'b0, acq_active[0]);
      ext_trigger_input_a <= 1'b0;
      ext_trigger_input_b <= 1'b1;
      repeat (8) @(posedge clk);
      chkb("acq_active", 1'b0, acq_active[0]);
      ext_trigger_input_b <= 1'b0;
      wait_act(0, 1'b1);
      rd("status", OFF_STATUS, 32'h22);
      wait_act(0, 1'b0);
      wr(OFF_CMD, 32'h10);
      rd("status", OFF_STATUS, 32'h21);
      ext_trigger_input_b <= 1'b1;
      repeat (6) @(posedge clk);
      ext_trigger_input_b <= 1'b0;
      wait_act(0, 1'b1);
      wait_act(0, 1'b0);
      // Starting just after a turn mark makes the number of recorded turns exact.
      @(posedge clk iff turn_strobe === 1'b1);
      sb_cnt = 0;
      int_trigger <= 2'h2;
      @(posedge clk);
      int_trigger <= 2'h0;
      wait_act(1, 1'b1);
      wait_act(1, 1'b0);
      repeat (4) @(posedge clk);
      chk("sample count", 32'h2, 32'(sb_cnt));
      chk("sample", 32'h0000_A003, {16'h0, sb_last});
      rd("current bunch", OFF_CUR_BUNCH, 32'h3);
      rd("sample count reg", OFF_SAMPLE_CNT, 32'h2);
      chkb("irq", 1'b1, irq);
      rd("irq status", OFF_IRQ_STATUS, 32'hF);
      chkb("irq", 1'b0, irq);
      stop_test();
   end
endmodule
